// File: heater_pkg.sv
// Shared constants and types for the heater command and status register bank
package heater_pkg;

	// Holding register indices
	localparam logic [15:0] REG_PRIVILEGE    = 16'h0000;
	localparam logic [15:0] REG_NET_ADDR     = 16'h0010;
	localparam logic [15:0] REG_LINK_TIMEOUT = 16'h0025;
	localparam logic [15:0] REG_COMMAND      = 16'h0036;
	localparam logic [15:0] REG_STATE        = 16'h003c;
	localparam logic [15:0] REG_DIAG         = 16'h003d;
	localparam logic [15:0] REG_ERR_LOW      = 16'h003e;
	localparam logic [15:0] REG_ERR_HIGH     = 16'h003f;

	// Command codes
	localparam logic [15:0] CMD_STANDBY        = 16'h0002;
	localparam logic [15:0] CMD_SOFT_RESET     = 16'h0003;
	localparam logic [15:0] CMD_PING           = 16'h0004;
	localparam logic [15:0] CMD_CLEAR_ERRORS   = 16'h0009;
	localparam logic [15:0] CMD_RESTORE_CONFIG = 16'h000a;
	localparam logic [15:0] CMD_RESTORE_ALL    = 16'h000b;
	localparam logic [15:0] CMD_EXIT_STANDBY   = 16'h000c;
	localparam logic [15:0] CMD_ADDR_RESET     = 16'h0064;
	localparam logic [15:0] CMD_CANCEL_PING    = 16'h0065;

	// Privilege select values
	localparam logic [15:0] PRIV_ADVANCED = 16'h0123;
	localparam logic [15:0] PRIV_NORMAL   = 16'h0000;

	// Factory defaults and limits
	localparam logic [15:0] DEF_NET_ADDR     = 16'h00f6;
	localparam logic [15:0] DEF_LINK_TIMEOUT = 16'h003c;
	localparam logic [15:0] NET_ADDR_MIN     = 16'h0001;
	localparam logic [15:0] ZERO_WORD        = 16'h0000;

	// Operating state codes as read back
	localparam logic [15:0] CODE_NORMAL     = 16'h0000;
	localparam logic [15:0] CODE_LOCKED     = 16'h0001;
	localparam logic [15:0] CODE_STANDBY    = 16'h0002;
	localparam logic [15:0] CODE_FATAL      = 16'h0003;
	localparam logic [15:0] CODE_BOOTLOADER = 16'h0004;
	localparam logic [15:0] CODE_BOOT_FAULT = 16'h0005;
	localparam logic [15:0] CODE_DEBUGGING  = 16'h0063;

	// Implemented bits of each status word; the rest read zero
	localparam logic [15:0] DIAG_VALID_MASK     = 16'h67ff;
	localparam logic [15:0] ERR_LOW_VALID_MASK  = 16'hbfff;
	localparam logic [15:0] ERR_HIGH_VALID_MASK = 16'h9ebf;
	// Fatal events survive the clear-errors command
	localparam logic [15:0] ERR_LOW_FATAL_MASK  = 16'ha040;
	localparam logic [15:0] ERR_HIGH_FATAL_MASK = 16'h0004;

	// Ping indication length
	localparam int unsigned PING_TIME_S = 30;
	localparam int unsigned CLOCK_HZ    = 20_000_000;
	localparam int unsigned PING_CYCLES = PING_TIME_S * CLOCK_HZ;

	typedef enum logic [2:0] {
		ST_NORMAL,
		ST_LOCKED,
		ST_STANDBY,
		ST_FATAL,
		ST_BOOTLOADER,
		ST_BOOT_FAULT,
		ST_DEBUGGING
	} op_state_t;

	typedef struct packed {
		logic       rsvd_15;
		logic       ambient_alert;
		logic       ambient_warning;
		logic [1:0] rsvd_12_11;
		logic       control_relay_closed;
		logic       safety_relay_closed;
		logic       thermocouple_two_fault;
		logic       thermocouple_one_fault;
		logic       over_current;
		logic       under_current;
		logic       long_term_temp_condition;
		logic       adc_error;
		logic       high_temp_alert;
		logic       low_temp_alert;
		logic       safety_limit_alarm;
	} diag_t;

	typedef struct packed {
		logic missing_app_image;
		logic rsvd_14;
		logic app_load_error;
		logic heater_missing;
		logic mains_heater_mismatch;
		logic cold_junction_difference;
		logic thermocouple_difference;
		logic low_temp_alert;
		logic high_temp_alert;
		logic hw_fw_mismatch;
		logic safety_limit_alarm;
		logic thermocouple_two_fault;
		logic thermocouple_one_fault;
		logic safety_limit_channel_two;
		logic safety_limit_channel_one;
		logic at_temperature;
	} err_low_t;

	typedef struct packed {
		logic       ambient_warning;
		logic [1:0] rsvd_14_13;
		logic       relay_stuck_open;
		logic       relay_stuck_closed;
		logic       adc_error;
		logic       rail_5v_fault;
		logic       rsvd_8;
		logic       ambient_alert;
		logic       rsvd_6;
		logic       long_term_temp_event;
		logic       under_current;
		logic       prior_watchdog_reset;
		logic       nvm_checksum_error;
		logic       nvm_access_error;
		logic       over_current;
	} err_high_t;

endpackage

// File: ping_timer.sv
// One-shot timer that holds the ping indication for a fixed number of cycles
`timescale 1ns/100ps
module ping_timer #(
	parameter int unsigned CYCLES = heater_pkg::PING_CYCLES
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst_b,
	// Control
	input  wire logic start,
	input  wire logic cancel,
	// Status
	output logic      active
);
	localparam int W = $clog2(CYCLES + 1);

	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;
	logic         active_reg;
	logic         active_next;

	always_comb begin
		count_next  = count_reg;
		active_next = active_reg;
		if (cancel) begin
			count_next  = '0;
			active_next = 1'b0;
		end else if (start) begin
			// A repeat start restarts the full sequence
			count_next  = W'(CYCLES - 1);
			active_next = 1'b1;
		end else if (active_reg) begin
			if (count_reg == '0) begin
				active_next = 1'b0;
			end else begin
				count_next = count_reg - 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			count_reg  <= '0;
			active_reg <= 1'b0;
		end else begin
			count_reg  <= count_next;
			active_reg <= active_next;
		end
	end

	assign active = active_reg;
endmodule

// File: heater_command_status_regs.sv
// Command decoder, privilege, state and status register bank of the heater controller
`timescale 1ns/100ps
// Contract
// - Code 2 enters standby, opening relays and stopping regulation.
// - Code 3 performs a software reset of the controller.
// - Code 4 starts a thirty second ping indication.
// - Code 9 (advanced) clears non-fatal errors and unlocks a locked device.
// - Code 10 (advanced) restores defaults except address, timeout and label.
// - Code 11 (advanced) restores all defaults including address and timeout.
// - Code 12 leaves standby and resumes regulation.
// - Code 100 (advanced) sets address 246 and timeout 60.
// - Code 101 ends an active ping at once, else nothing.
// - Diagnostic word at register 61, read-only, one means active.
// - Diagnostic bits 0 to 3: safety limit, low, high alert, converter.
// - Diagnostic bits 9 and 10 show safety and control relay closed.
// - Diagnostic bits 4 to 8, 13 and 14 as listed conditions.
// - Error word one at register 62, bits 0 to 5 as listed.
// - Error word one bits 6 to 10 as listed.
// - Error word one bits 11 to 13 and 15; bit 14 reserved.
// - Error word two at register 63, bits 0 to 5 as listed.
// - Error word two bits 7, 9 to 12 and 15 as listed.
// - Operating state at register 60 with codes 0 to 5 and 99.
// - Command register reads back zero always.
module heater_command_status_regs #(
	parameter int unsigned PING_CYCLES = heater_pkg::PING_CYCLES
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rst_b,
	// Holding register access
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [15:0]       reg_addr,
	input  wire logic [15:0]       reg_wdata,
	output logic      [15:0]       reg_rdata,
	output logic                   reg_rdata_valid,
	// Live conditions and events
	input  wire heater_pkg::diag_t     diag_in,
	input  wire heater_pkg::err_low_t  err_low_evt,
	input  wire heater_pkg::err_high_t err_high_evt,
	input  wire logic              lock_req,
	input  wire logic              fatal_req,
	input  wire logic              boot_fault_req,
	input  wire logic              bootloader_req,
	input  wire logic              debug_req,
	// Controller outputs
	output logic                   regulation_on,
	output logic                   relays_allowed,
	output logic                   ping_active,
	output logic                   soft_reset_pulse,
	output logic                   restore_config_pulse,
	output logic                   restore_all_pulse,
	output logic                   advanced_level,
	output logic      [15:0]       network_address,
	output logic      [15:0]       link_timeout
);
	logic rst_meta_b;
	logic rst_sync_b;

	// Reset release through two flops
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_b <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_b <= 1'b1;
			rst_sync_b <= rst_meta_b;
		end
	end

	heater_pkg::op_state_t state_reg;
	heater_pkg::op_state_t state_next;
	logic [15:0] priv_reg;
	logic [15:0] priv_next;
	logic [15:0] addr_reg;
	logic [15:0] addr_next;
	logic [15:0] timeout_reg;
	logic [15:0] timeout_next;
	logic [15:0] err_low_reg;
	logic [15:0] err_low_next;
	logic [15:0] err_high_reg;
	logic [15:0] err_high_next;
	logic [15:0] diag_reg;
	logic [15:0] diag_next;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic        rvalid_reg;
	logic        rvalid_next;
	logic        run_reg;
	logic        run_next;
	logic        reset_p_reg;
	logic        cfg_p_reg;
	logic        all_p_reg;

	logic cmd_wr;
	logic adv;
	logic do_standby;
	logic do_reset;
	logic do_ping;
	logic do_clear;
	logic do_cfg;
	logic do_all;
	logic do_exit;
	logic do_addr;
	logic do_cancel;

	function automatic logic [15:0] state_code(heater_pkg::op_state_t s);
		unique case (s)
			heater_pkg::ST_NORMAL:     state_code = heater_pkg::CODE_NORMAL;
			heater_pkg::ST_LOCKED:     state_code = heater_pkg::CODE_LOCKED;
			heater_pkg::ST_STANDBY:    state_code = heater_pkg::CODE_STANDBY;
			heater_pkg::ST_FATAL:      state_code = heater_pkg::CODE_FATAL;
			heater_pkg::ST_BOOTLOADER: state_code = heater_pkg::CODE_BOOTLOADER;
			heater_pkg::ST_BOOT_FAULT: state_code = heater_pkg::CODE_BOOT_FAULT;
			heater_pkg::ST_DEBUGGING:  state_code = heater_pkg::CODE_DEBUGGING;
			default:                   state_code = heater_pkg::CODE_FATAL;
		endcase
	endfunction

	// Command decode
	always_comb begin
		cmd_wr     = reg_wr && (reg_addr == heater_pkg::REG_COMMAND);
		adv        = (priv_reg == heater_pkg::PRIV_ADVANCED);
		// Advanced codes need the raised level; anything else unlisted falls through
		do_standby = cmd_wr && (reg_wdata == heater_pkg::CMD_STANDBY);
		do_reset   = cmd_wr && (reg_wdata == heater_pkg::CMD_SOFT_RESET);
		do_ping    = cmd_wr && (reg_wdata == heater_pkg::CMD_PING);
		do_clear   = cmd_wr && adv && (reg_wdata == heater_pkg::CMD_CLEAR_ERRORS);
		do_cfg     = cmd_wr && adv && (reg_wdata == heater_pkg::CMD_RESTORE_CONFIG);
		do_all     = cmd_wr && adv && (reg_wdata == heater_pkg::CMD_RESTORE_ALL);
		do_exit    = cmd_wr && (reg_wdata == heater_pkg::CMD_EXIT_STANDBY);
		do_addr    = cmd_wr && adv && (reg_wdata == heater_pkg::CMD_ADDR_RESET);
		do_cancel  = cmd_wr && (reg_wdata == heater_pkg::CMD_CANCEL_PING);
	end

	ping_timer #(
		.CYCLES (PING_CYCLES)
	) u_ping (
		.clock  (clock),
		.rst_b  (rst_sync_b),
		.start  (do_ping),
		.cancel (do_cancel || do_reset),
		.active (ping_active)
	);

	// State, privilege and configuration
	always_comb begin
		state_next   = state_reg;
		priv_next    = priv_reg;
		addr_next    = addr_reg;
		timeout_next = timeout_reg;
		if (reg_wr && reg_addr == heater_pkg::REG_PRIVILEGE) begin
			if (reg_wdata == heater_pkg::PRIV_ADVANCED || reg_wdata == heater_pkg::PRIV_NORMAL) begin
				priv_next = reg_wdata;
			end
		end
		if (reg_wr && adv && reg_addr == heater_pkg::REG_NET_ADDR) begin
			// Out-of-range addresses would orphan the device, so they are dropped
			if (reg_wdata >= heater_pkg::NET_ADDR_MIN && reg_wdata <= heater_pkg::DEF_NET_ADDR) begin
				addr_next = reg_wdata;
			end
		end
		if (reg_wr && adv && reg_addr == heater_pkg::REG_LINK_TIMEOUT) begin
			timeout_next = reg_wdata;
		end
		if (do_all || do_addr) begin
			addr_next    = heater_pkg::DEF_NET_ADDR;
			timeout_next = heater_pkg::DEF_LINK_TIMEOUT;
		end
		if (do_all) begin
			priv_next = heater_pkg::PRIV_NORMAL;
		end
		unique case (state_reg)
			heater_pkg::ST_NORMAL: begin
				if (do_standby) begin
					state_next = heater_pkg::ST_STANDBY;
				end else if (lock_req) begin
					state_next = heater_pkg::ST_LOCKED;
				end else if (bootloader_req) begin
					state_next = heater_pkg::ST_BOOTLOADER;
				end else if (debug_req) begin
					state_next = heater_pkg::ST_DEBUGGING;
				end
			end
			heater_pkg::ST_LOCKED: begin
				if (do_clear) begin
					state_next = heater_pkg::ST_NORMAL;
				end
			end
			heater_pkg::ST_STANDBY: begin
				if (do_exit) begin
					state_next = heater_pkg::ST_NORMAL;
				end
			end
			heater_pkg::ST_DEBUGGING: begin
				if (!debug_req) begin
					state_next = heater_pkg::ST_NORMAL;
				end
			end
			heater_pkg::ST_BOOTLOADER, heater_pkg::ST_FATAL, heater_pkg::ST_BOOT_FAULT: begin
				state_next = state_reg;
			end
		endcase
		if (boot_fault_req) begin
			state_next = heater_pkg::ST_BOOT_FAULT;
		end else if (fatal_req) begin
			state_next = heater_pkg::ST_FATAL;
		end
		// Software reset reinitialises everything but the stored link settings
		if (do_reset) begin
			state_next = heater_pkg::ST_NORMAL;
			priv_next  = heater_pkg::PRIV_NORMAL;
		end
		run_next = (state_next == heater_pkg::ST_NORMAL) ||
			(state_next == heater_pkg::ST_DEBUGGING);
	end

	// Status words; a new event wins over a clear in the same cycle
	always_comb begin
		diag_next = diag_in & heater_pkg::DIAG_VALID_MASK;
		err_low_next  = err_low_reg;
		err_high_next = err_high_reg;
		if (do_clear) begin
			err_low_next  = err_low_reg & heater_pkg::ERR_LOW_FATAL_MASK;
			err_high_next = err_high_reg & heater_pkg::ERR_HIGH_FATAL_MASK;
		end
		if (do_reset) begin
			err_low_next  = '0;
			err_high_next = '0;
		end
		err_low_next  = err_low_next | (err_low_evt & heater_pkg::ERR_LOW_VALID_MASK);
		err_high_next = err_high_next | (err_high_evt & heater_pkg::ERR_HIGH_VALID_MASK);
	end

	// Read data
	always_comb begin
		rvalid_next = reg_rd;
		rdata_next  = rdata_reg;
		if (reg_rd) begin
			unique case (reg_addr)
				heater_pkg::REG_COMMAND:      rdata_next = heater_pkg::ZERO_WORD;
				heater_pkg::REG_STATE:        rdata_next = state_code(state_reg);
				heater_pkg::REG_DIAG:         rdata_next = diag_reg;
				heater_pkg::REG_ERR_LOW:      rdata_next = err_low_reg;
				heater_pkg::REG_ERR_HIGH:     rdata_next = err_high_reg;
				heater_pkg::REG_PRIVILEGE:    rdata_next = priv_reg;
				heater_pkg::REG_NET_ADDR:     rdata_next = addr_reg;
				heater_pkg::REG_LINK_TIMEOUT: rdata_next = timeout_reg;
				default:                      rdata_next = heater_pkg::ZERO_WORD;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			state_reg    <= heater_pkg::ST_NORMAL;
			priv_reg     <= heater_pkg::PRIV_NORMAL;
			addr_reg     <= heater_pkg::DEF_NET_ADDR;
			timeout_reg  <= heater_pkg::DEF_LINK_TIMEOUT;
			err_low_reg  <= '0;
			err_high_reg <= '0;
			diag_reg     <= '0;
			rdata_reg    <= '0;
			rvalid_reg   <= 1'b0;
			run_reg      <= 1'b0;
			reset_p_reg  <= 1'b0;
			cfg_p_reg    <= 1'b0;
			all_p_reg    <= 1'b0;
		end else begin
			state_reg    <= state_next;
			priv_reg     <= priv_next;
			addr_reg     <= addr_next;
			timeout_reg  <= timeout_next;
			err_low_reg  <= err_low_next;
			err_high_reg <= err_high_next;
			diag_reg     <= diag_next;
			rdata_reg    <= rdata_next;
			rvalid_reg   <= rvalid_next;
			run_reg      <= run_next;
			reset_p_reg  <= do_reset;
			cfg_p_reg    <= do_cfg;
			all_p_reg    <= do_all;
		end
	end

	assign reg_rdata            = rdata_reg;
	assign reg_rdata_valid      = rvalid_reg;
	assign regulation_on        = run_reg;
	assign relays_allowed       = run_reg;
	assign soft_reset_pulse     = reset_p_reg;
	assign restore_config_pulse = cfg_p_reg;
	assign restore_all_pulse    = all_p_reg;
	assign advanced_level       = (priv_reg == heater_pkg::PRIV_ADVANCED);
	assign network_address      = addr_reg;
	assign link_timeout         = timeout_reg;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_sync_b);

	AST_STANDBY_ENTRY: assert property (
		do_standby && state_reg == heater_pkg::ST_NORMAL && !fatal_req && !boot_fault_req
		|=> state_reg == heater_pkg::ST_STANDBY ##1 !relays_allowed && !regulation_on)
		else $error("standby command did not stop regulation");
	AST_SOFT_RESET: assert property (
		do_reset |=> soft_reset_pulse && state_reg == heater_pkg::ST_NORMAL && !advanced_level)
		else $error("software reset did not reinitialise");
	AST_PING_START: assert property (
		do_ping ##1 (!do_cancel && !do_reset) [*7] |=> ping_active)
		else $error("ping indication did not start");
	AST_CLEAR_ERRORS: assert property (
		do_clear && err_low_evt == '0 && err_high_evt == '0
		|=> (err_low_reg & ~heater_pkg::ERR_LOW_FATAL_MASK) == '0 &&
			(err_high_reg & ~heater_pkg::ERR_HIGH_FATAL_MASK) == '0)
		else $error("clear errors left non-fatal flags");
	AST_UNLOCK: assert property (
		do_clear && state_reg == heater_pkg::ST_LOCKED && !fatal_req && !boot_fault_req
		|=> state_reg == heater_pkg::ST_NORMAL)
		else $error("clear errors did not unlock");
	AST_RESTORE_CONFIG: assert property (
		do_cfg |=> restore_config_pulse && $stable(network_address) && $stable(link_timeout))
		else $error("config restore touched link settings");
	AST_RESTORE_ALL: assert property (
		do_all |=> restore_all_pulse && network_address == heater_pkg::DEF_NET_ADDR)
		else $error("full restore missed the address");
	AST_EXIT_STANDBY: assert property (
		do_exit && state_reg == heater_pkg::ST_STANDBY && !fatal_req && !boot_fault_req
		|=> ##1 regulation_on && relays_allowed)
		else $error("exit standby did not resume");
	AST_ADDR_RESET: assert property (
		do_addr |=> network_address == heater_pkg::DEF_NET_ADDR &&
			link_timeout == heater_pkg::DEF_LINK_TIMEOUT)
		else $error("address reset values wrong");
	AST_PING_CANCEL: assert property (
		do_cancel |=> !ping_active)
		else $error("ping not cancelled");
	AST_STATE_CODE: assert property (
		reg_rd && reg_addr == heater_pkg::REG_STATE
		|=> reg_rdata_valid && reg_rdata == state_code($past(state_reg)))
		else $error("state code read mismatch");
	AST_CMD_READS_ZERO: assert property (
		reg_rd && reg_addr == heater_pkg::REG_COMMAND |=> reg_rdata_valid && reg_rdata == '0)
		else $error("command register read not zero");
	AST_NORMAL_LEVEL_IGNORED: assert property (
		cmd_wr && !adv && (reg_wdata == heater_pkg::CMD_RESTORE_ALL ||
			reg_wdata == heater_pkg::CMD_RESTORE_CONFIG || reg_wdata == heater_pkg::CMD_ADDR_RESET)
		|=> !restore_all_pulse && !restore_config_pulse && $stable(network_address))
		else $error("advanced command ran at normal level");
	AST_RESERVED_ZERO: assert property (
		reg_rd |=> (reg_rdata & ~(($past(reg_addr) == heater_pkg::REG_DIAG) ?
			heater_pkg::DIAG_VALID_MASK : ($past(reg_addr) == heater_pkg::REG_ERR_LOW) ?
			heater_pkg::ERR_LOW_VALID_MASK : ($past(reg_addr) == heater_pkg::REG_ERR_HIGH) ?
			heater_pkg::ERR_HIGH_VALID_MASK : 16'hffff)) == '0)
		else $error("reserved status bit read as one");

	COV_STANDBY_CYCLE: cover property (do_standby ##[1:50] do_exit);
	COV_PING_CANCEL: cover property (do_ping ##[1:20] do_cancel);
	COV_UNLOCK: cover property (state_reg == heater_pkg::ST_LOCKED && do_clear);
	COV_RESTORE_ALL: cover property (do_all);
endmodule

// File: register_master.sv
// Holding register master model that issues command, privilege and status accesses
`timescale 1ns/100ps
module register_master (
	// Clock
	input  wire logic        clock,
	// Holding register access
	output logic             reg_wr,
	output logic             reg_rd,
	output logic      [15:0] reg_addr,
	output logic      [15:0] reg_wdata,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_rdata_valid
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
	end
	// Released lines show the inverse of the last value so stale data is never mistaken
	task automatic write(input logic [15:0] addr, input logic [15:0] data);
		@(negedge clock);
		reg_addr = addr;
		reg_wdata = data;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
		reg_addr = ~addr;
		reg_wdata = ~data;
	endtask
	// Answer is registered, so it is taken one cycle after the strobe edge
	task automatic read(input logic [15:0] addr, output logic [15:0] data, output logic v);
		@(negedge clock);
		reg_addr = addr;
		reg_rd = 1'b1;
		@(negedge clock);
		data = reg_rdata;
		v = reg_rdata_valid;
		reg_rd = 1'b0;
		reg_addr = ~addr;
	endtask
	task automatic cmd(input logic [15:0] code);
		write(heater_pkg::REG_COMMAND, code);
	endtask
	task automatic priv(input logic [15:0] level);
		write(heater_pkg::REG_PRIVILEGE, level);
	endtask
endmodule

// File: test_heater_command_status_regs.sv
// Self-checking bench for the heater command and status register bank
`timescale 1ns/100ps
module test_heater_command_status_regs;
	localparam int unsigned PING = 20;
	logic                  clock = 1'b0;
	logic                  rst_b = 1'b0;
	logic                  reg_wr;
	logic                  reg_rd;
	logic [15:0]           reg_addr;
	logic [15:0]           reg_wdata;
	logic [15:0]           reg_rdata;
	logic                  reg_rdata_valid;
	heater_pkg::diag_t     diag_in = '0;
	heater_pkg::err_low_t  err_low_evt = '0;
	heater_pkg::err_high_t err_high_evt = '0;
	logic [3:0]            reqs = 4'h0;
	logic                  debug_req = 1'b0;
	logic                  reg_on, relays, ping, sr_p, rc_p, ra_p, adv;
	logic [15:0]           net_addr, timeout;
	int                    miscompares = 0;
	int                    compares = 0;
	int                    cycles = 0;
	logic [15:0]           n_sr = 16'h0000, n_rc = 16'h0000, n_ra = 16'h0000;
	always #25 clock = ~clock;
	register_master register_master_inst (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rdata_valid(reg_rdata_valid));
	heater_command_status_regs #(.PING_CYCLES(PING)) heater_command_status_regs_inst (
		.clock(clock), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
		.diag_in(diag_in), .err_low_evt(err_low_evt), .err_high_evt(err_high_evt),
		.lock_req(reqs[0]), .fatal_req(reqs[1]), .boot_fault_req(reqs[2]),
		.bootloader_req(reqs[3]), .debug_req(debug_req), .regulation_on(reg_on),
		.relays_allowed(relays), .ping_active(ping), .soft_reset_pulse(sr_p),
		.restore_config_pulse(rc_p), .restore_all_pulse(ra_p), .advanced_level(adv),
		.network_address(net_addr), .link_timeout(timeout));
	always @(posedge clock) begin
		n_sr <= n_sr + {15'h0000, sr_p};
		n_rc <= n_rc + {15'h0000, rc_p};
		n_ra <= n_ra + {15'h0000, ra_p};
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			miscompares++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rd(input logic [15:0] addr, input logic [15:0] exp);
		logic [15:0] d;
		logic        v;
		register_master_inst.read(addr, d, v);
		check("valid", {15'h0000, v}, 16'h0001);
		check($sformatf("reg %h", addr), d, exp);
	endtask
	task automatic strobe(input logic [3:0] v);
		@(negedge clock);
		reqs = v;
		@(negedge clock);
		reqs = 4'h0;
	endtask
	task automatic c(input logic [15:0] code);
		register_master_inst.cmd(code);
		repeat (2) @(negedge clock);
	endtask
	initial begin
		repeat (8) @(negedge clock);
		rst_b = 1'b1;
		repeat (4) @(negedge clock);
		c(16'h0065);
		c(16'h0007);
		rd(heater_pkg::REG_STATE, heater_pkg::CODE_NORMAL);
		rd(heater_pkg::REG_COMMAND, 16'h0000);
		diag_in = heater_pkg::diag_t'(16'hffff);
		rd(heater_pkg::REG_DIAG, 16'h67ff);
		diag_in = heater_pkg::diag_t'(16'h0201);
		rd(heater_pkg::REG_DIAG, 16'h0201);
		err_low_evt = heater_pkg::err_low_t'(16'hffff);
		err_high_evt = heater_pkg::err_high_t'(16'hffff);
		@(negedge clock);
		err_low_evt = '0;
		err_high_evt = '0;
		c(heater_pkg::CMD_CLEAR_ERRORS);
		rd(heater_pkg::REG_ERR_LOW, 16'hbfff);
		rd(heater_pkg::REG_ERR_HIGH, 16'h9ebf);
		register_master_inst.priv(heater_pkg::PRIV_ADVANCED);
		strobe(4'h1);
		rd(heater_pkg::REG_STATE, heater_pkg::CODE_LOCKED);
		c(heater_pkg::CMD_CLEAR_ERRORS);
		rd(heater_pkg::REG_ERR_LOW, 16'ha040);
		rd(heater_pkg::REG_ERR_HIGH, 16'h0004);
		rd(heater_pkg::REG_STATE, heater_pkg::CODE_NORMAL);
		$display("Test status and clear done");
		c(heater_pkg::CMD_STANDBY);
		rd(heater_pkg::REG_STATE, heater_pkg::CODE_STANDBY);
		check("relays", {14'h0000, reg_on, relays}, 16'h0000);
		c(heater_pkg::CMD_EXIT_STANDBY);
		check("relays", {14'h0000, reg_on, relays}, 16'h0003);
		c(heater_pkg::CMD_PING);
		repeat (PING - 6) @(negedge clock);
		check("ping", {15'h0000, ping}, 16'h0001);
		repeat (6) @(negedge clock);
		check("ping", {15'h0000, ping}, 16'h0000);
		c(heater_pkg::CMD_PING);
		c(heater_pkg::CMD_CANCEL_PING);
		check("ping", {15'h0000, ping}, 16'h0000);
		$display("Test standby and ping done");
		register_master_inst.write(heater_pkg::REG_NET_ADDR, 16'h0005);
		register_master_inst.write(heater_pkg::REG_LINK_TIMEOUT, 16'h0007);
		c(heater_pkg::CMD_RESTORE_CONFIG);
		check("address", net_addr, 16'h0005);
		check("timeout", timeout, 16'h0007);
		check("restore", n_rc, 16'h0001);
		c(heater_pkg::CMD_ADDR_RESET);
		check("address", net_addr, 16'h00f6);
		check("timeout", timeout, 16'h003c);
		c(heater_pkg::CMD_RESTORE_ALL);
		check("restore", {adv, n_ra[14:0]}, 16'h0001);
		c(heater_pkg::CMD_RESTORE_CONFIG);
		check("restore", n_rc, 16'h0001);
		strobe(4'h8);
		rd(heater_pkg::REG_STATE, heater_pkg::CODE_BOOTLOADER);
		c(heater_pkg::CMD_SOFT_RESET);
		rd(heater_pkg::REG_STATE, heater_pkg::CODE_NORMAL);
		rd(heater_pkg::REG_ERR_LOW, 16'h0000);
		check("soft reset", n_sr, 16'h0001);
		debug_req = 1'b1;
		rd(heater_pkg::REG_STATE, heater_pkg::CODE_DEBUGGING);
		debug_req = 1'b0;
		strobe(4'h2);
		rd(heater_pkg::REG_STATE, heater_pkg::CODE_FATAL);
		strobe(4'h4);
		rd(heater_pkg::REG_STATE, heater_pkg::CODE_BOOT_FAULT);
		$display("Test config and states done");
		stop_test();
	end
endmodule
